/* qd_ctrl.sv */
// qd_ctrl.sv - apb register file, accumulators, events and interrupt of the
// quadrature decoder; instantiates qd_core for timing and phase decoding.
// assumes: apb master on pclk; encoder phases and led are board pins.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "qd_defines.svh"

module qd_ctrl
    import qd_pkg::*;
#(
    parameter logic [`QD_TMR_W-1:0] BASE_CYC = `QD_BASE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // encoder pins
    input wire logic phase_a,
    input wire logic phase_b,
    output logic led_out,
    output logic led_oe_n,
    // pin ownership and interrupt
    output logic pins_owned,
    output logic irq
);

    // ************************************************************
    // declarations
    // ************************************************************
    qd_evt_t int_en_r, int_en_nxt; // interrupt enable mask
    qd_evt_t status_r, status_nxt; // sticky event status
    qd_evt_t events_c; // one-cycle event pulses
    qd_evt_t clr_c; // status clear from software
    logic dec_en_r, dec_en_nxt; // decoder enable
    logic dec_en_d_r; // enable one cycle late
    logic led_pol_r, led_pol_nxt; // led active level
    logic [`QD_PER_W-1:0] per_r, per_nxt; // sample period code
    logic [`QD_REP_W-1:0] rep_per_r, rep_per_nxt; // samples per report
    logic [`QD_REP_W-1:0] rep_cnt_r, rep_cnt_nxt; // samples so far
    logic [`QD_ACC_W-1:0] acc_r, acc_nxt; // motion accumulator
    logic [`QD_DBL_W-1:0] dbl_r, dbl_nxt; // double transition count
    logic [31:0] prdata_r, prdata_nxt; // read data latched at setup
    logic err_r, err_nxt; // unmapped address seen at setup
    logic wr_c; // write taken this edge
    logic setup_c; // apb setup phase
    logic clr_acc_c; // accumulator clear task
    logic rep_done_c; // report period complete
    logic ovf_c; // accumulator would overflow
    logic [`QD_REP_W-1:0] rep_lim_c; // report period, zero as one
    logic tick; // sample taken
    qd_step_e step; // decoded step
    logic [`QD_SMP_W-1:0] smp_val; // last motion sample

    // ************************************************************
    // sample timer and phase decoder
    // ************************************************************
    qd_core #(
        .BASE_CYC(BASE_CYC)
    ) u_core (
        .pclk(pclk),
        .presetn(presetn),
        .enable(dec_en_r),
        .period_sel(per_r),
        .phase_a(phase_a),
        .phase_b(phase_b),
        .sample_tick(tick),
        .step(step),
        .sample_val(smp_val)
    );

    // ************************************************************
    // apb strobes
    // ************************************************************
    // zero wait states: data was latched in the setup cycle
    assign setup_c = psel & ~penable;
    assign wr_c = psel & penable & pwrite & ~err_r;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_r;
    assign prdata = prdata_r;

    // ************************************************************
    // read mux, evaluated in the setup cycle
    // ************************************************************
    // registers hold stable across the access phase only if nothing
    // changes underneath; status may move, so the setup value is kept
    always_comb begin
        prdata_nxt = prdata_r;
        err_nxt = err_r;
        if (setup_c) begin
            prdata_nxt = `QD_RST_WORD;
            err_nxt = 1'b0;
            if (paddr == `QD_OFS_INT_ENABLE) begin
                prdata_nxt[`QD_EVT_NUM-1:0] = int_en_r;
            end else if (paddr == `QD_OFS_INT_DISABLE) begin
                prdata_nxt[`QD_EVT_NUM-1:0] = int_en_r;
            end else if (paddr == `QD_OFS_DEC_ENABLE) begin
                prdata_nxt[0] = dec_en_r;
            end else if (paddr == `QD_OFS_LED_POL) begin
                prdata_nxt[0] = led_pol_r;
            end else if (paddr == `QD_OFS_SAMPLE_PER) begin
                prdata_nxt[`QD_PER_W-1:0] = per_r;
            end else if (paddr == `QD_OFS_SAMPLE) begin
                // sign extend the motion sample
                prdata_nxt = {{(32-`QD_SMP_W){smp_val[`QD_SMP_W-1]}}, smp_val};
            end else if (paddr == `QD_OFS_REPORT_PER) begin
                prdata_nxt[`QD_REP_W-1:0] = rep_per_r;
            end else if (paddr == `QD_OFS_ACC) begin
                prdata_nxt = {{(32-`QD_ACC_W){acc_r[`QD_ACC_W-1]}}, acc_r};
            end else if (paddr == `QD_OFS_DBL_ACC) begin
                prdata_nxt[`QD_DBL_W-1:0] = dbl_r;
            end else if (paddr == `QD_OFS_EVT_STATUS) begin
                prdata_nxt[`QD_EVT_NUM-1:0] = status_r;
            end else if (paddr == `QD_OFS_EVT_CLEAR || paddr == `QD_OFS_TASK) begin
                // write-only: reads as zero
                prdata_nxt = `QD_RST_WORD;
            end else begin
                // unmapped: error on the access phase
                err_nxt = 1'b1;
            end
        end
    end

    // ************************************************************
    // software-written configuration
    // ************************************************************
    always_comb begin
        int_en_nxt = int_en_r;
        dec_en_nxt = dec_en_r;
        led_pol_nxt = led_pol_r;
        per_nxt = per_r;
        rep_per_nxt = rep_per_r;
        clr_c = '0;
        clr_acc_c = 1'b0;
        if (wr_c) begin
            if (paddr == `QD_OFS_INT_ENABLE) begin
                // ones set, zeros leave alone
                int_en_nxt = int_en_r | pwdata[`QD_EVT_NUM-1:0];
            end else if (paddr == `QD_OFS_INT_DISABLE) begin
                // ones clear, zeros leave alone
                int_en_nxt = int_en_r & ~pwdata[`QD_EVT_NUM-1:0];
            end else if (paddr == `QD_OFS_DEC_ENABLE) begin
                dec_en_nxt = pwdata[0];
            end else if (paddr == `QD_OFS_LED_POL) begin
                led_pol_nxt = pwdata[0];
            end else if (paddr == `QD_OFS_SAMPLE_PER) begin
                per_nxt = pwdata[`QD_PER_W-1:0];
            end else if (paddr == `QD_OFS_REPORT_PER) begin
                rep_per_nxt = pwdata[`QD_REP_W-1:0];
            end else if (paddr == `QD_OFS_EVT_CLEAR) begin
                clr_c = pwdata[`QD_EVT_NUM-1:0];
            end else if (paddr == `QD_OFS_TASK) begin
                clr_acc_c = pwdata[`QD_TASK_CLR_BIT];
            end else begin
                // read-only or unmapped: no effect
                clr_c = '0;
            end
        end
    end

    // ************************************************************
    // accumulators and report period
    // ************************************************************
    // saturating accumulator: an overflow drops the step, never wraps
    always_comb begin
        acc_nxt = acc_r;
        dbl_nxt = dbl_r;
        rep_cnt_nxt = rep_cnt_r;
        ovf_c = 1'b0;
        rep_lim_c = (rep_per_r == '0) ? 4'h1 : rep_per_r;
        rep_done_c = tick && ((rep_cnt_r + 1'b1) >= rep_lim_c);
        if (tick) begin
            if (step == QD_STEP_FWD) begin
                if (acc_r == `QD_ACC_MAX) begin
                    ovf_c = 1'b1;
                end else begin
                    acc_nxt = acc_r + 1'b1;
                end
            end else if (step == QD_STEP_REV) begin
                if (acc_r == `QD_ACC_MIN) begin
                    ovf_c = 1'b1;
                end else begin
                    acc_nxt = acc_r - 1'b1;
                end
            end else if (step == QD_STEP_DBL) begin
                if (dbl_r != `QD_DBL_MAX) begin
                    dbl_nxt = dbl_r + 1'b1;
                end
            end
            rep_cnt_nxt = rep_done_c ? '0 : (rep_cnt_r + 1'b1);
        end
        // clear task wins over a sample in the same cycle
        if (clr_acc_c) begin
            acc_nxt = '0;
            dbl_nxt = '0;
        end
        // a disabled decoder starts its report period afresh
        if (!dec_en_r) begin
            rep_cnt_nxt = '0;
        end
    end

    // ************************************************************
    // events
    // ************************************************************
    always_comb begin
        events_c = '0;
        events_c[`QD_EVT_SAMPLE_RDY] = tick;
        events_c[`QD_EVT_REPORT_RDY] = rep_done_c && (acc_nxt != '0);
        events_c[`QD_EVT_ACC_OVF] = ovf_c;
        events_c[`QD_EVT_DBL_RDY] = rep_done_c && (dbl_nxt != '0);
        events_c[`QD_EVT_STOPPED] = dec_en_d_r & ~dec_en_r;
    end

    // sticky status per bit: a new event wins over a clear
    for (genvar i = 0; i < `QD_EVT_NUM; i++) begin : g_status
        assign status_nxt[i] = events_c[i] | (status_r[i] & ~clr_c[i]);
    end

    // level interrupt, high while an enabled status bit is set
    assign irq = |(status_r & int_en_r);

    // ************************************************************
    // pin ownership
    // ************************************************************
    // led lit while decoding; released to gpio when disabled
    assign pins_owned = dec_en_r;
    assign led_oe_n = ~dec_en_r;
    assign led_out = dec_en_r ? led_pol_r : 1'b0;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_r <= '0;
            status_r <= '0;
            dec_en_r <= 1'b0;
            dec_en_d_r <= 1'b0;
            led_pol_r <= 1'b0;
            per_r <= '0;
            rep_per_r <= '0;
            rep_cnt_r <= '0;
            acc_r <= '0;
            dbl_r <= '0;
            prdata_r <= `QD_RST_WORD;
            err_r <= 1'b0;
        end else begin
            int_en_r <= int_en_nxt;
            status_r <= status_nxt;
            dec_en_r <= dec_en_nxt;
            dec_en_d_r <= dec_en_r;
            led_pol_r <= led_pol_nxt;
            per_r <= per_nxt;
            rep_per_r <= rep_per_nxt;
            rep_cnt_r <= rep_cnt_nxt;
            acc_r <= acc_nxt;
            dbl_r <= dbl_nxt;
            prdata_r <= prdata_nxt;
            err_r <= err_nxt;
        end
    end

endmodule : qd_ctrl

/* qd_defines.svh */
// qd_defines.svh - offsets, field positions, reset values and timing counts of the
// quadrature decoder control block.
// assumes: included by bare name from the package and the design modules.
`ifndef QD_DEFINES_SVH
`define QD_DEFINES_SVH

// ************************************************************
// register byte offsets (apb, one aligned word each)
// ************************************************************
`define QD_OFS_INT_ENABLE 12'h304
`define QD_OFS_INT_DISABLE 12'h308
`define QD_OFS_DEC_ENABLE 12'h500
`define QD_OFS_LED_POL 12'h504
`define QD_OFS_SAMPLE_PER 12'h508
`define QD_OFS_SAMPLE 12'h50C
`define QD_OFS_REPORT_PER 12'h510
`define QD_OFS_ACC 12'h514
`define QD_OFS_DBL_ACC 12'h544
`define QD_OFS_EVT_STATUS 12'h600
`define QD_OFS_EVT_CLEAR 12'h604
`define QD_OFS_TASK 12'h608

// ************************************************************
// event bit positions, shared by mask, status and clear
// ************************************************************
`define QD_EVT_SAMPLE_RDY 0
`define QD_EVT_REPORT_RDY 1
`define QD_EVT_ACC_OVF 2
`define QD_EVT_DBL_RDY 3
`define QD_EVT_STOPPED 4
`define QD_EVT_NUM 5

// ************************************************************
// field widths, limits and reset values
// ************************************************************
`define QD_PER_W 4
`define QD_PER_MAX 4'hA
`define QD_REP_W 4
`define QD_ACC_W 11
`define QD_ACC_MAX 11'h3FF
`define QD_ACC_MIN 11'h400
`define QD_DBL_W 4
`define QD_DBL_MAX 4'hF
`define QD_SMP_W 3
`define QD_RST_WORD 32'h0000_0000
`define QD_TASK_CLR_BIT 0

// ************************************************************
// timing: shortest sample period and its cycle count
// ************************************************************
`define QD_CLK_MHZ 50
`define QD_BASE_PERIOD_US 128
`define QD_BASE_CYC 24'(`QD_BASE_PERIOD_US * `QD_CLK_MHZ)
`define QD_TMR_W 24

`endif

/* qd_pkg.sv */
// qd_pkg.sv - types of the quadrature decoder control block.
// assumes: qd_defines.svh is on the include path.
`include "qd_defines.svh"

package qd_pkg;
    // one decoded phase step per sample
    typedef enum logic [1:0] {
        QD_STEP_NONE,
        QD_STEP_FWD,
        QD_STEP_REV,
        QD_STEP_DBL
    } qd_step_e;

    // event vector, one bit per event
    typedef logic [`QD_EVT_NUM-1:0] qd_evt_t;
endpackage : qd_pkg

/* qd_core.sv */
// qd_core.sv - sample timer and phase decoder of the quadrature decoder.
// assumes: phase pins are asynchronous; enable and period come from pclk logic.
`timescale 1ns/1ps
`include "qd_defines.svh"

module qd_core
    import qd_pkg::*;
#(
    parameter logic [`QD_TMR_W-1:0] BASE_CYC = `QD_BASE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic enable,
    input wire logic [`QD_PER_W-1:0] period_sel,
    // phase pins
    input wire logic phase_a,
    input wire logic phase_b,
    // results
    output logic sample_tick,
    output qd_step_e step,
    output logic [`QD_SMP_W-1:0] sample_val
);

    // ************************************************************
    // state
    // ************************************************************
    logic [1:0] sync1_r; // first stage, read only by sync2_r
    logic [1:0] sync2_r; // stable phase levels
    logic [1:0] prev_r, prev_nxt; // levels at the last sample
    logic [`QD_TMR_W-1:0] tmr_r, tmr_nxt; // period timer
    logic [`QD_SMP_W-1:0] smp_r, smp_nxt; // last motion sample
    logic tick_r, tick_nxt;
    qd_step_e step_r, step_nxt;
    logic [`QD_PER_W-1:0] sel_c; // clamped code
    logic [`QD_TMR_W-1:0] limit_c; // last timer count

    // ************************************************************
    // next state
    // ************************************************************
    // codes above the top value run at the longest period
    always_comb begin
        sel_c = (period_sel > `QD_PER_MAX) ? `QD_PER_MAX : period_sel;
        limit_c = (BASE_CYC << sel_c) - 1'b1;
        tmr_nxt = tmr_r;
        prev_nxt = prev_r;
        smp_nxt = smp_r;
        tick_nxt = 1'b0;
        step_nxt = QD_STEP_NONE;
        if (!enable) begin
            // disabled: timer cleared, pins tracked without a step
            tmr_nxt = '0;
            prev_nxt = sync2_r;
        end else if (tmr_r >= limit_c) begin
            // end of period: take a sample
            tmr_nxt = '0;
            tick_nxt = 1'b1;
            prev_nxt = sync2_r;
            if (sync2_r == prev_r) begin
                smp_nxt = 3'h0;
            end else if (sync2_r == ~prev_r) begin
                // both phases moved: direction unknown
                step_nxt = QD_STEP_DBL;
                smp_nxt = 3'h2;
            end else if ({prev_r, sync2_r} == 4'h1 || {prev_r, sync2_r} == 4'h7 ||
                         {prev_r, sync2_r} == 4'hE || {prev_r, sync2_r} == 4'h8) begin
                step_nxt = QD_STEP_FWD;
                smp_nxt = 3'h1;
            end else begin
                step_nxt = QD_STEP_REV;
                smp_nxt = 3'h7;
            end
        end else begin
            tmr_nxt = tmr_r + 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            prev_r <= 2'h0;
            tmr_r <= '0;
            smp_r <= 3'h0;
            tick_r <= 1'b0;
            step_r <= QD_STEP_NONE;
        end else begin
            sync1_r <= {phase_a, phase_b};
            sync2_r <= sync1_r;
            prev_r <= prev_nxt;
            tmr_r <= tmr_nxt;
            smp_r <= smp_nxt;
            tick_r <= tick_nxt;
            step_r <= step_nxt;
        end
    end

    assign sample_tick = tick_r;
    assign step = step_r;
    assign sample_val = smp_r;

endmodule : qd_core

/* qd_chk.sv */
// qd_chk.sv - port assertions for the quadrature decoder control block.
// assumes: bound to qd_ctrl; the apb master keeps the two-phase protocol.
`timescale 1ns/1ps
`include "qd_defines.svh"

module qd_chk #(
    parameter logic [`QD_TMR_W-1:0] BASE_CYC = `QD_BASE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // encoder pins and status
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic led_out,
    input wire logic led_oe_n,
    input wire logic pins_owned,
    input wire logic irq
);
    // ************************************************************
    // shadow of the interrupt enable mask
    // ************************************************************
    logic [4:0] mask_r; // expected mask, kept from bus writes only
    logic [4:0] mask_nxt; // next shadow value
    logic wr_acc; // write completing at this edge
    assign wr_acc = psel && penable && pready && pwrite;

    // set and clear addresses share one mask
    always_comb begin
        mask_nxt = mask_r;
        if (wr_acc && paddr == `QD_OFS_INT_ENABLE) begin
            mask_nxt = mask_r | pwdata[4:0];
        end else if (wr_acc && paddr == `QD_OFS_INT_DISABLE) begin
            mask_nxt = mask_r & ~pwdata[4:0];
        end
    end

    // all interrupts start disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 5'h00;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [11:0] a);
        wr_acc && paddr == a;
    endsequence
    sequence s_mask_rd;
        psel && penable && !pwrite && (paddr == 12'h304 || paddr == 12'h308);
    endsequence

    chk_pins_free: assert property (!pins_owned |-> led_oe_n && !led_out)
        else $error("led pin driven while decoder disabled");
    chk_enable_on: assert property ((s_wr(12'h500) ##0 pwdata[0]) |=> pins_owned)
        else $error("decoder did not take its pins");
    chk_enable_off: assert property ((s_wr(12'h500) ##0 !pwdata[0]) |=> !pins_owned [*2])
        else $error("decoder kept its pins after disable");
    chk_oe_driven: assert property (pins_owned |-> !led_oe_n)
        else $error("led not driven while enabled");
    chk_owned_hold: assert property (pins_owned && !(wr_acc && paddr == 12'h500) |=> pins_owned)
        else $error("pin ownership dropped without a write");
    chk_mask_read: assert property (s_mask_rd |-> prdata == {27'h0, mask_r})
        else $error("mask read differs from written state");
    chk_irq_masked: assert property (irq |-> mask_r != 5'h00)
        else $error("interrupt with every source disabled");
    chk_mask_off: assert property ((s_wr(12'h308) ##0 pwdata[4:0] == 5'h1F) |=> !irq)
        else $error("interrupt stays after full disable");
    chk_mask_mapped: assert property (s_mask_rd |-> !pslverr)
        else $error("mask access flagged as error");
endmodule : qd_chk

bind qd_ctrl qd_chk #(.BASE_CYC(BASE_CYC)) u_qd_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a(phase_a), .phase_b(phase_b), .led_out(led_out), .led_oe_n(led_oe_n),
    .pins_owned(pins_owned), .irq(irq)
);

/* qd_enc.sv */
// qd_enc.sv - behavioural quadrature encoder with an led input.
// assumes: moved by the bench through move(); shares pclk for timing.
`timescale 1ns/1ps

module qd_enc (
    // clock
    input wire logic pclk,
    // led from the decoder
    input wire logic led_out,
    input wire logic led_oe_n,
    // phase pins
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] pos_r = 2'h0; // position index in the gray cycle
    logic led_lit; // led really lit, only meaningful while driven
    assign led_lit = !led_oe_n && led_out;

    // index 0..3 maps to 00, 01, 11, 10: counting up is forward
    always_comb begin
        phase_a = pos_r[1];
        phase_b = pos_r[1] ^ pos_r[0];
    end

    // a jump of two states is a double transition
    task automatic move(input logic [1:0] n);
        @(posedge pclk);
        pos_r <= pos_r + n;
    endtask : move
endmodule : qd_enc

/* qd_tb.sv */
// qd_tb.sv - self-checking bench of the quadrature decoder control block.
// assumes: qd_ctrl with a short base period, qd_enc on the phase pins.
`timescale 1ns/1ps
`include "qd_defines.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module testbench
    import qd_pkg::*;
;
    localparam int BASE = 8; // shortened 128 us period
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, cyc;
    logic phase_a, phase_b, led_out, led_oe_n, pins_owned, irq, edum;
    int error_cnt = 0;
    int n_tests = 0;

    qd_ctrl #(.BASE_CYC(24'(BASE))) u_qd_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_a(phase_a), .phase_b(phase_b),
        .led_out(led_out), .led_oe_n(led_oe_n), .pins_owned(pins_owned), .irq(irq));
    qd_enc u_qd_enc (.pclk(pclk), .led_out(led_out), .led_oe_n(led_oe_n),
        .phase_a(phase_a), .phase_b(phase_b));

    // ************************************************************
    // clock, cycle count and bus tasks
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= presetn ? cyc + 32'h1 : 32'h0;

    // one apb transfer; request held until pready is seen high
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        `CHK("pready", 1'b1, pready)
        rdat = prdata;
        edum = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        `CHK(nm, exp, rdat)
    endtask : rd_chk

    // bounded wait for the interrupt line, returns the cycle seen
    task automatic wait_irq(output logic [31:0] t);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(posedge pclk);
            if (irq === 1'b1) break;
        end
        if (i == 20000) error_cnt++;
        t = cyc;
    endtask : wait_irq

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs;
        rd_chk("disable_mask", `QD_OFS_INT_DISABLE, 32'h0);
        rd_chk("enable_mask", `QD_OFS_INT_ENABLE, 32'h0);
        rd_chk("dec_enable", `QD_OFS_DEC_ENABLE, 32'h0);
        rd_chk("period_sel", `QD_OFS_SAMPLE_PER, 32'h0);
        `CHK("released", 1'b1, led_oe_n)
        xfer(12'h700, 1'b0, 32'h0);
        `CHK("unmapped_err", 1'b1, edum)
        $display("test regs done");
    endtask : t_regs

    // every event bit set through one mask and cleared through the other
    task automatic t_mask;
        for (int i = 0; i < 5; i++) begin
            wr(`QD_OFS_INT_ENABLE, 32'h1 << i);
            rd_chk("mask_set", `QD_OFS_INT_DISABLE, 32'h1 << i);
            wr(`QD_OFS_INT_DISABLE, 32'h1 << i);
            rd_chk("mask_clr", `QD_OFS_INT_ENABLE, 32'h0);
        end
        $display("test mask done");
    endtask : t_mask

    task automatic t_enable;
        wr(`QD_OFS_LED_POL, 32'h1);
        wr(`QD_OFS_INT_ENABLE, 32'h10);
        wr(`QD_OFS_DEC_ENABLE, 32'h1);
        `CHK("owned", 1'b1, pins_owned)
        `CHK("led_driven", 1'b0, led_oe_n)
        `CHK("led_lit", 1'b1, u_qd_enc.led_lit)
        wr(`QD_OFS_DEC_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        #1;
        `CHK("led_free", 1'b1, led_oe_n)
        `CHK("irq_stopped", 1'b1, irq)
        wr(`QD_OFS_INT_DISABLE, 32'h10);
        `CHK("irq_masked", 1'b0, irq)
        wr(`QD_OFS_INT_ENABLE, 32'h10);
        `CHK("irq_unmasked", 1'b1, irq)
        wr(`QD_OFS_EVT_CLEAR, 32'h10);
        `CHK("irq_cleared", 1'b0, irq)
        wr(`QD_OFS_INT_DISABLE, 32'h1F);
        $display("test enable done");
    endtask : t_enable

    // distance between two sample-ready interrupts for codes 0 to 10
    task automatic t_period;
        logic [31:0] t0, t1;
        wr(`QD_OFS_INT_ENABLE, 32'h1);
        for (int code = 0; code <= 10; code++) begin
            wr(`QD_OFS_DEC_ENABLE, 32'h0);
            wr(`QD_OFS_SAMPLE_PER, 32'(code));
            wr(`QD_OFS_EVT_CLEAR, 32'h1F);
            wr(`QD_OFS_DEC_ENABLE, 32'h1);
            wait_irq(t0);
            wr(`QD_OFS_EVT_CLEAR, 32'h1);
            wait_irq(t1);
            `CHK("period", 32'(BASE << code), t1 - t0)
        end
        wr(`QD_OFS_INT_DISABLE, 32'h1F);
        $display("test period done");
    endtask : t_period

    // idle, one forward step, a double transition, then a reverse step
    task automatic t_motion;
        wr(`QD_OFS_DEC_ENABLE, 32'h0);
        wr(`QD_OFS_SAMPLE_PER, 32'h0);
        wr(`QD_OFS_REPORT_PER, 32'h2);
        wr(`QD_OFS_DEC_ENABLE, 32'h1);
        wr(`QD_OFS_TASK, 32'h1);
        wr(`QD_OFS_EVT_CLEAR, 32'h1F);
        repeat (6 * BASE) @(posedge pclk);
        rd_chk("no_motion", `QD_OFS_EVT_STATUS, 32'h1);
        u_qd_enc.move(2'h1);
        repeat (6 * BASE) @(posedge pclk);
        rd_chk("acc", `QD_OFS_ACC, 32'h1);
        rd_chk("last_sample", `QD_OFS_SAMPLE, 32'h0);
        xfer(`QD_OFS_EVT_STATUS, 1'b0, 32'h0);
        `CHK("report_rdy", 32'h2, rdat & 32'hA)
        wr(`QD_OFS_EVT_CLEAR, 32'h1F);
        u_qd_enc.move(2'h2);
        repeat (6 * BASE) @(posedge pclk);
        rd_chk("dbl_acc", `QD_OFS_DBL_ACC, 32'h1);
        xfer(`QD_OFS_EVT_STATUS, 1'b0, 32'h0);
        `CHK("dbl_rdy", 32'h8, rdat & 32'h8)
        u_qd_enc.move(2'h3);
        repeat (6 * BASE) @(posedge pclk);
        rd_chk("acc_rev", `QD_OFS_ACC, 32'h0);
        $display("test motion done");
    endtask : t_motion

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // main sequence after a 16 cycle reset
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_mask();
        t_enable();
        t_period();
        t_motion();
        close_out();
    end

    // watchdog well above the expected 33k cycles
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        close_out();
    end
endmodule : testbench
